// ==== hdl/asp_pkg.sv ====
/*
 holds register offsets, control bit positions, reset values and frame
 constants of the async serial port, plus the packed carrier structs.
 assumes a single 40 MHz system clock and a byte-wide register port.
*/
package asp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_STAT = 8'h22;
    localparam logic [7:0] ADDR_DATA      = 8'h23;
    localparam logic [7:0] ADDR_RATE_LO   = 8'h24;
    localparam logic [7:0] ADDR_RATE_HI   = 8'h25;
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] DATA_RST       = 8'h00;
    localparam logic [15:0] RATE_RST      = 16'h0000;

    // ------------------------------------------------------------
    // control/status bit positions
    // ------------------------------------------------------------
    localparam int BIT_TX_EN      = 0;
    localparam int BIT_TX_IRQ_SEL = 1;
    localparam int BIT_EIGHT      = 2;
    localparam int BIT_PAR_EN     = 3;
    localparam int BIT_PAR_EVEN   = 4;
    localparam int BIT_RX_EN      = 5;
    localparam int BIT_SEMA       = 6;
    localparam int BIT_RX_ERR     = 7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [3:0] HALF_BIT = 4'h7;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       eight;
        logic       parEn;
        logic       parEven;
    } asp_fmt_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       parErr;
        logic       frameErr;
    } asp_rxchar_t;

    function automatic logic asp_parity(input logic [7:0] d, input logic eight,
                                        input logic even);
        logic p;
        p = ^d[6:0] ^ (eight & d[7]);
        return even ? p : ~p;
    endfunction
endpackage

// ==== hdl/asp_tx.sv ====
/*
 transmit shifter of the async serial port: frames one character per load.
 assumes a one-cycle 16x tick enable and a format held stable per frame.
*/
`timescale 1ns/1ps
module asp_tx (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    // control
    input  wire logic            tick16,
    input  wire asp_pkg::asp_fmt_t fmt,
    input  wire logic            load,
    input  wire logic [7:0]      loadData,
    // status and line
    output logic                 busy,
    output logic                 txLine
);
    logic [10:0] shift_ff;
    logic [10:0] nxt_shift;
    logic [3:0]  bits_ff;
    logic [3:0]  nxt_bits;
    logic [3:0]  ovs_ff;
    logic [3:0]  nxt_ovs;
    logic        line_ff;
    logic        nxt_line;
    logic        par;

    assign busy   = (bits_ff != 4'h0);
    assign txLine = line_ff;

    always_comb begin
        nxt_shift = shift_ff;
        nxt_bits  = bits_ff;
        nxt_ovs   = ovs_ff;
        nxt_line  = line_ff;
        par       = asp_pkg::asp_parity(loadData, fmt.eight, fmt.parEven);
        if (load && bits_ff == 4'h0) begin
            // start, lsb-first data, parity or stop, stops; always 11 or 10 slots
            if (fmt.eight) begin
                nxt_shift = {1'b1, fmt.parEn ? par : 1'b1, loadData, 1'b0};
                nxt_bits  = 4'hb;
            end else begin
                // seven-bit: bit 7 dropped; no parity gives two stops
                nxt_shift = {1'b1, 1'b1, fmt.parEn ? par : 1'b1, loadData[6:0], 1'b0};
                nxt_bits  = 4'ha;
            end
            nxt_ovs = 4'h0;
        end else if (tick16 && bits_ff != 4'h0) begin
            if (ovs_ff == 4'h0) begin
                nxt_line = shift_ff[0];
            end
            nxt_ovs = ovs_ff + 4'h1; // sixteen ticks per bit
            if (ovs_ff == asp_pkg::OVS_LAST) begin
                nxt_shift = {1'b1, shift_ff[10:1]};
                nxt_bits  = bits_ff - 4'h1;
            end
        end
        if (bits_ff == 4'h0 && !load) begin
            nxt_line = 1'b1; // idle high
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            shift_ff <= 11'h7ff;
            bits_ff  <= 4'h0;
            ovs_ff   <= 4'h0;
            line_ff  <= 1'b1;
        end else begin
            shift_ff <= nxt_shift;
            bits_ff  <= nxt_bits;
            ovs_ff   <= nxt_ovs;
            line_ff  <= nxt_line;
        end
    end
endmodule

// ==== hdl/asp_rx.sv ====
/*
 receive sampler of the async serial port: 16x oversampled, mid-bit strobe.
 assumes rxLine synchronous to clk_sys and a one-cycle 16x tick enable.
*/
`timescale 1ns/1ps
module asp_rx (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // control
    input  wire logic              tick16,
    input  wire logic              enable,
    input  wire asp_pkg::asp_fmt_t fmt,
    // line and result
    input  wire logic              rxLine,
    output asp_pkg::asp_rxchar_t   rxChar
);
    typedef enum logic [3:0] {
        ASP_IDLE  = 4'b0001,
        ASP_START = 4'b0010,
        ASP_DATA  = 4'b0100,
        ASP_STOP  = 4'b1000
    } asp_rxst_t;

    asp_rxst_t            st_ff;
    asp_rxst_t            nxt_st;
    logic [3:0]           ovs_ff;
    logic [3:0]           nxt_ovs;
    logic [3:0]           idx_ff;
    logic [3:0]           nxt_idx;
    logic [8:0]           sh_ff;
    logic [8:0]           nxt_sh;
    asp_pkg::asp_rxchar_t out_ff;
    asp_pkg::asp_rxchar_t nxt_out;
    logic [3:0]           nbits;
    logic [7:0]           dat;

    assign rxChar = out_ff;

    always_comb begin
        nxt_st  = st_ff;
        nxt_ovs = ovs_ff;
        nxt_idx = idx_ff;
        nxt_sh  = sh_ff;
        nxt_out = out_ff;
        nxt_out.valid = 1'b0;
        nbits = (fmt.eight ? 4'h8 : 4'h7) + {3'h0, fmt.parEn};
        dat   = fmt.eight ? sh_ff[7:0] : {1'b0, sh_ff[6:0]};
        if (!enable) begin
            nxt_st = ASP_IDLE; // receiver held off
        end else if (tick16) begin
            nxt_ovs = ovs_ff + 4'h1; // sixteen ticks per bit
            unique case (st_ff)
                ASP_IDLE: begin
                    nxt_ovs = 4'h0;
                    if (!rxLine) begin
                        nxt_st = ASP_START;
                    end
                end
                ASP_START: begin
                    // low must last half a bit, else false start
                    if (rxLine) begin
                        nxt_st = ASP_IDLE;
                    end else if (ovs_ff == asp_pkg::HALF_BIT) begin
                        nxt_st  = ASP_DATA;
                        nxt_ovs = 4'h0;
                        nxt_idx = 4'h0;
                    end
                end
                ASP_DATA: begin
                    if (ovs_ff == asp_pkg::OVS_LAST) begin
                        // one sample per bit at its centre
                        nxt_sh = {rxLine, sh_ff[8:1]};
                        if (idx_ff == nbits - 4'h1) begin
                            nxt_st = ASP_STOP;
                        end
                        nxt_idx = idx_ff + 4'h1;
                    end
                end
                ASP_STOP: begin
                    // a single stop bit suffices
                    if (ovs_ff == asp_pkg::OVS_LAST) begin
                        nxt_st = ASP_IDLE;
                        nxt_out.valid    = 1'b1;
                        nxt_out.frameErr = ~rxLine;
                        nxt_out.data     = dat;
                        nxt_out.parErr   = fmt.parEn & (sh_ff[8] !=
                            asp_pkg::asp_parity(dat, fmt.eight, fmt.parEven));
                    end
                end
            endcase
        end
        // align shifter so data lands in low bits
        if (nxt_st == ASP_STOP && st_ff == ASP_DATA) begin
            nxt_sh = fmt.parEn ? (fmt.eight ? nxt_sh : {nxt_sh[8], 1'b0, nxt_sh[7:1]})
                               : (fmt.eight ? {1'b0, nxt_sh[8:1]} : {2'b00, nxt_sh[8:2]});
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_ff  <= ASP_IDLE;
            ovs_ff <= 4'h0;
            idx_ff <= 4'h0;
            sh_ff  <= 9'h000;
            out_ff <= '0;
        end else begin
            st_ff  <= nxt_st;
            ovs_ff <= nxt_ovs;
            idx_ff <= nxt_idx;
            sh_ff  <= nxt_sh;
            out_ff <= nxt_out;
        end
    end
endmodule

// ==== hdl/asp_top.sv ====
/*
 async serial port top: register port, rate divider, tx and rx shifters,
 interrupt outputs. assumes a 40 MHz clk_sys and synchronous line inputs.
*/
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module asp_top (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic [7:0]      regRdata,
    // serial line
    input  wire logic       rxLine,
    output logic            txLine,
    // interrupts
    output logic            txIrq,
    output logic            rxIrq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  ctrl_ff;
    logic [7:0]  nxt_ctrl;
    logic [7:0]  rxData_ff;
    logic [7:0]  nxt_rxData;
    logic        rxFull_ff;
    logic        nxt_rxFull;
    logic [7:0]  hold_ff;
    logic [7:0]  nxt_hold;
    logic        holdFull_ff;
    logic        nxt_holdFull;
    logic [15:0] rate_ff;
    logic [15:0] nxt_rate;
    logic [15:0] div_ff;
    logic [15:0] nxt_div;
    logic        tick_ff;
    logic        nxt_tick;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        txIrq_ff;
    logic        nxt_txIrq;
    logic        rxIrq_ff;
    logic        nxt_rxIrq;

    logic                 txBusy;
    logic                 txLoad;
    logic                 txLineInt;
    logic                 txLine_ff;
    asp_pkg::asp_fmt_t    fmt;
    asp_pkg::asp_rxchar_t rxChar;

    assign fmt.eight   = ctrl_ff[asp_pkg::BIT_EIGHT];
    assign fmt.parEn   = ctrl_ff[asp_pkg::BIT_PAR_EN];
    assign fmt.parEven = ctrl_ff[asp_pkg::BIT_PAR_EVEN];
    assign txLoad      = holdFull_ff && !txBusy && ctrl_ff[asp_pkg::BIT_TX_EN];

    assign regRdata = rdata_ff;
    assign txIrq    = txIrq_ff;
    assign rxIrq    = rxIrq_ff;
    assign txLine   = txLine_ff;

    // ------------------------------------------------------------
    // rate divider: reload value set by software
    // ------------------------------------------------------------
    always_comb begin
        nxt_div  = div_ff - 16'h0001;
        nxt_tick = 1'b0;
        if (div_ff == 16'h0000) begin
            // tick every rate+1 clocks; software owns the divisor
            nxt_div  = rate_ff;
            nxt_tick = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_comb begin
        nxt_ctrl     = ctrl_ff;
        nxt_rxData   = rxData_ff;
        nxt_rxFull   = rxFull_ff;
        nxt_hold     = hold_ff;
        nxt_holdFull = holdFull_ff;
        nxt_rate     = rate_ff;
        nxt_rdata    = 8'h00;
        if (txLoad) begin
            nxt_holdFull = 1'b0;
        end
        if (regWr) begin
            unique case (regAddr)
                asp_pkg::ADDR_CTRL_STAT: begin
                    nxt_ctrl[6:0] = regWdata[6:0];
                    if (regWdata[asp_pkg::BIT_RX_ERR]) begin
                        nxt_ctrl[asp_pkg::BIT_RX_ERR] = 1'b0; // write one clears
                    end
                end
                asp_pkg::ADDR_DATA: begin
                    nxt_hold     = regWdata;
                    nxt_holdFull = 1'b1;
                end
                asp_pkg::ADDR_RATE_LO: nxt_rate[7:0]  = regWdata;
                asp_pkg::ADDR_RATE_HI: nxt_rate[15:8] = regWdata;
                default: ;
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                asp_pkg::ADDR_CTRL_STAT: nxt_rdata = ctrl_ff;
                asp_pkg::ADDR_DATA: begin
                    nxt_rdata  = rxData_ff;
                    nxt_rxFull = 1'b0;
                end
                asp_pkg::ADDR_RATE_LO: nxt_rdata = rate_ff[7:0];
                asp_pkg::ADDR_RATE_HI: nxt_rdata = rate_ff[15:8];
                default: nxt_rdata = 8'h00;
            endcase
        end
        if (rxChar.valid && ctrl_ff[asp_pkg::BIT_RX_EN]) begin
            nxt_rxData = rxChar.data;
            nxt_rxFull = 1'b1;
            // errors set after the clear so a coincident event wins
            if (rxChar.frameErr || rxChar.parErr || rxFull_ff) begin
                nxt_ctrl[asp_pkg::BIT_RX_ERR] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    always_comb begin
        // holding empty, or holding and shifter empty
        nxt_txIrq = ctrl_ff[asp_pkg::BIT_TX_EN] &&
                    (ctrl_ff[asp_pkg::BIT_TX_IRQ_SEL] ? (!holdFull_ff && !txBusy)
                                                     : !holdFull_ff);
        // level while received data waits unread
        nxt_rxIrq = ctrl_ff[asp_pkg::BIT_RX_EN] && nxt_rxFull;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_ff     <= asp_pkg::CTRL_RST;
            rxData_ff   <= asp_pkg::DATA_RST;
            rxFull_ff   <= 1'b0;
            hold_ff     <= asp_pkg::DATA_RST;
            holdFull_ff <= 1'b0;
            rate_ff     <= asp_pkg::RATE_RST;
            div_ff      <= asp_pkg::RATE_RST;
            tick_ff     <= 1'b0;
            rdata_ff    <= 8'h00;
            txIrq_ff    <= 1'b0;
            rxIrq_ff    <= 1'b0;
            txLine_ff   <= 1'b1;
        end else begin
            ctrl_ff     <= nxt_ctrl;
            rxData_ff   <= nxt_rxData;
            rxFull_ff   <= nxt_rxFull;
            hold_ff     <= nxt_hold;
            holdFull_ff <= nxt_holdFull;
            rate_ff     <= nxt_rate;
            div_ff      <= nxt_div;
            tick_ff     <= nxt_tick;
            rdata_ff    <= nxt_rdata;
            txIrq_ff    <= nxt_txIrq;
            rxIrq_ff    <= nxt_rxIrq;
            txLine_ff   <= txLineInt;
        end
    end

    // ------------------------------------------------------------
    // shifters
    // ------------------------------------------------------------
    asp_tx u_tx (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .tick16   (tick_ff),
        .fmt      (fmt),
        .load     (txLoad),
        .loadData (hold_ff),
        .busy     (txBusy),
        .txLine   (txLineInt)
    );

    // mid-bit sampling leaves margin for a few percent mismatch
    asp_rx u_rx (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tick16  (tick_ff),
        .enable  (ctrl_ff[asp_pkg::BIT_RX_EN]),
        .fmt     (fmt),
        .rxLine  (rxLine),
        .rxChar  (rxChar)
    );
endmodule

// ==== testbench/asp_top_assertions.sv ====
/*
 checker for the async serial port top, watching its ports only.
 assumes clk_sys with a synchronous active-high sys_rst; bound below.
*/
`timescale 1ns/1ps
module asp_top_checker (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    // line and interrupts
    input wire logic       rxLine,
    input wire logic       txLine,
    input wire logic       txIrq,
    input wire logic       rxIrq
);
    logic ctlWr;
    logic ctlRd;
    logic datRd;
    assign ctlWr = regWr && regAddr == asp_pkg::ADDR_CTRL_STAT;
    assign ctlRd = regRd && regAddr == asp_pkg::ADDR_CTRL_STAT;
    assign datRd = regRd && regAddr == asp_pkg::ADDR_DATA;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_ctrl_echo: assert property (ctlWr ##2 ctlRd
        |=> regRdata[6:0] == $past(regWdata[6:0], 3))
        else $error("control bits not read back");
    a_err_clear: assert property (ctlWr && regWdata[7] ##2 ctlRd |=> !regRdata[7])
        else $error("error bit survived write of one");

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    a_txirq_off: assert property (ctlWr && !regWdata[0] |-> ##[1:3] !txIrq)
        else $error("tx irq with transmitter disabled");
    a_rxirq_off: assert property (ctlWr && !regWdata[5] |-> ##[1:3] !rxIrq)
        else $error("rx irq with receiver disabled");
    a_read_clears: assert property (datRd && rxIrq |-> ##[1:3] !rxIrq)
        else $error("rx irq stays after data read");

    // ------------------------------------------------------------
    // line: a bit is sixteen ticks, a tick at least one clock
    // ------------------------------------------------------------
    a_reset_idle: assert property ($fell(sys_rst) |-> txLine && !txIrq && !rxIrq)
        else $error("line or irq wrong after reset");
    a_low_bit: assert property ($fell(txLine) |-> !txLine [*8] ##1 !txLine [*8])
        else $error("low bit shorter than sixteen clocks");
    a_high_bit: assert property ($rose(txLine) |-> txLine [*8] ##1 txLine [*8])
        else $error("high bit shorter than sixteen clocks");

    c_tx_frame: cover property ($fell(txLine));
    c_rx_char: cover property ($rose(rxIrq));
    c_err_seen: cover property (ctlRd ##1 regRdata[7]);
endmodule

bind asp_top asp_top_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .rxLine(rxLine), .txLine(txLine), .txIrq(txIrq), .rxIrq(rxIrq));

// ==== testbench/asp_remote.sv ====
/*
 far-end serial device: drives the port's receive line, samples its
 transmit line. assumes both ends agree on BIT_CLKS clocks per bit.
*/
`timescale 1ns/1ps
module asp_remote #(
    parameter int BIT_CLKS = 32
) (
    // clock
    input  wire logic clk_sys,
    // serial lines, named as at the port
    input  wire logic txLine,
    output logic      rxLine
);
    initial rxLine = 1'b1;

    // first bit may be cut short to fake a glitch; bitClks skews the rate
    task automatic send(input logic [10:0] f, input int n, input int startClks,
                        input int bitClks = BIT_CLKS);
        for (int i = 0; i < n; i++) begin
            rxLine <= f[i];
            repeat (i == 0 ? startClks : bitClks) @(posedge clk_sys);
        end
        rxLine <= 1'b1;
        // one edge of idle so a following frame never rewrites the line in this step
        @(posedge clk_sys);
    endtask

    // samples mid-bit; a missing frame leaves bit zero high
    task automatic grab(output logic [10:0] f);
        int k;
        f = 'x;
        k = 0;
        while (txLine && k < 20000) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        repeat (BIT_CLKS / 2) @(posedge clk_sys);
        for (int i = 0; i < 11; i++) begin
            #1 f[i] = txLine;
            repeat (BIT_CLKS) @(posedge clk_sys);
        end
    endtask
endmodule

// ==== testbench/asp_top_test.sv ====
/*
 self-checking bench for the async serial port: register tasks and a
 far-end model. assumes divisor one, so a bit lasts 32 clocks.
*/
`timescale 1ns/1ps
module asp_top_test;
    logic        clk_sys;
    logic        sys_rst;
    logic [7:0]  regAddr;
    logic [7:0]  regWdata;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regRdata;
    logic        rxLine;
    logic        txLine;
    logic        txIrq;
    logic        rxIrq;
    logic [10:0] f;
    logic [7:0]  v;
    logic [7:0]  e;
    int          mismatches;
    int          samples_checked;
    localparam int BITC = 32;
    localparam logic [7:0] TXE = 8'h01 << asp_pkg::BIT_TX_EN;
    localparam logic [7:0] SEL = 8'h01 << asp_pkg::BIT_TX_IRQ_SEL;
    localparam logic [7:0] EIG = 8'h01 << asp_pkg::BIT_EIGHT;
    localparam logic [7:0] PEN = 8'h01 << asp_pkg::BIT_PAR_EN;
    localparam logic [7:0] PEV = 8'h01 << asp_pkg::BIT_PAR_EVEN;
    localparam logic [7:0] RXE = 8'h01 << asp_pkg::BIT_RX_EN;
    localparam logic [7:0] ERR = 8'h01 << asp_pkg::BIT_RX_ERR;
    localparam logic [7:0] CSR = asp_pkg::ADDR_CTRL_STAT;
    localparam logic [7:0] DAT = asp_pkg::ADDR_DATA;
    localparam logic [7:0] P8E = EIG | PEN | PEV;
    logic [7:0] fmts [5] = '{EIG, P8E, EIG | PEN, 8'h00, PEN | PEV};
    logic [7:0] dats [5] = '{8'ha5, 8'h3c, 8'h81, 8'hd3, 8'h7e};

    asp_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxLine(rxLine),
        .txLine(txLine), .txIrq(txIrq), .rxIrq(rxIrq));
    asp_remote #(.BIT_CLKS(BITC)) far (.clk_sys(clk_sys), .txLine(txLine), .rxLine(rxLine));

    always #12.5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // wire order from bit zero; seven-bit sends two stops
    function automatic logic [10:0] frame(input logic [7:0] d, input logic [7:0] c);
        logic [7:0] m;
        logic       pb;
        m  = c[asp_pkg::BIT_EIGHT] ? d : {1'b0, d[6:0]};
        pb = c[asp_pkg::BIT_PAR_EN] ? (^m ^ ~c[asp_pkg::BIT_PAR_EVEN]) : 1'b1;
        return c[asp_pkg::BIT_EIGHT] ? {1'b1, pb, m, 1'b0} : {2'b11, pb, m[6:0], 1'b0};
    endfunction

    function automatic int rxLen(input logic [7:0] c);
        return (c[asp_pkg::BIT_EIGHT] ? 10 : 9) + int'(c[asp_pkg::BIT_PAR_EN]);
    endfunction

    task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(what, {3'b000, v}, {3'b000, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // a hang costs about six times the expected run
    initial begin
        #(25 * 40000);
        mismatches++;
        close_out;
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1 chk("reset line irqs", 11'({txLine, txIrq, rxIrq}), 11'h4);
        rdchk("ctrl reset", CSR, 8'h00);
        rdchk("data reset", DAT, 8'h00);
        rdchk("unmapped", 8'h40, 8'h00);
        wr(asp_pkg::ADDR_RATE_LO, 8'h01);
        wr(asp_pkg::ADDR_RATE_HI, 8'h00);
        rdchk("rate low", asp_pkg::ADDR_RATE_LO, 8'h01);
        wr(CSR, 8'h40 | PEV);
        rdchk("ctrl echo", CSR, 8'h40 | PEV);
        $display("test register map done");
        for (int i = 0; i < 5; i++) begin
            wr(CSR, fmts[i] | TXE);
            wr(DAT, dats[i]);
            far.grab(f);
            chk("tx frame", f, frame(dats[i], fmts[i]));
            tick(BITC);
            chk("tx irq idle", 11'(txIrq), 11'h1);
        end
        wr(CSR, TXE | SEL | EIG);
        tick(3);
        chk("tx irq all empty", 11'(txIrq), 11'h1);
        wr(DAT, 8'h55);
        tick(3 * BITC);
        chk("tx irq shifting", 11'(txIrq), 11'h0);
        wr(CSR, TXE | EIG);
        tick(3);
        chk("tx irq hold empty", 11'(txIrq), 11'h1);
        tick(12 * BITC);
        wr(CSR, EIG);
        tick(3);
        chk("tx irq disabled", 11'(txIrq), 11'h0);
        $display("test transmitter done");
        for (int i = 0; i < 5; i++) begin
            wr(CSR, fmts[i] | RXE);
            far.send(frame(dats[i], fmts[i]), rxLen(fmts[i]), BITC);
            tick(3);
            chk("rx irq", 11'(rxIrq), 11'h1);
            e = fmts[i][asp_pkg::BIT_EIGHT] ? dats[i] : {1'b0, dats[i][6:0]};
            rdchk("rx data", DAT, e);
            rdchk("rx status", CSR, fmts[i] | RXE);
        end
        wr(CSR, P8E | RXE);
        // sender about three percent slow: still within the tolerated mismatch
        far.send(frame(8'h5a, P8E), 11, BITC + 1, BITC + 1);
        rdchk("skew data", DAT, 8'h5a);
        rdchk("skew status", CSR, P8E | RXE);
        f = frame(8'h96, P8E);
        f[9] = ~f[9];
        far.send(f, 11, BITC);
        rdchk("parity error", CSR, P8E | RXE | ERR);
        rd(DAT);
        wr(CSR, P8E | RXE);
        rdchk("error kept", CSR, P8E | RXE | ERR);
        wr(CSR, P8E | RXE | ERR);
        rdchk("error cleared", CSR, P8E | RXE);
        f = frame(8'h96, P8E);
        f[10] = 1'b0;
        far.send(f, 11, BITC);
        rdchk("framing error", CSR, P8E | RXE | ERR);
        rd(DAT);
        wr(CSR, RXE | ERR);
        far.send(frame(8'h11, 8'h00), 9, BITC);
        far.send(frame(8'h2e, 8'h00), 9, BITC);
        rdchk("overrun status", CSR, RXE | ERR);
        rdchk("overrun data", DAT, 8'h2e);
        wr(CSR, RXE | ERR);
        far.send(11'h7fe, 1, BITC / 4);
        tick(12 * BITC);
        chk("false start", 11'(rxIrq), 11'h0);
        wr(CSR, 8'h00);
        far.send(frame(8'h33, 8'h00), 9, BITC);
        tick(3);
        chk("rx disabled irq", 11'(rxIrq), 11'h0);
        rdchk("rx disabled status", CSR, 8'h00);
        $display("test receiver done");
        close_out;
    end
endmodule
